// ---- pkg/power_mode_pkg.sv ----
// Shared constants and types of the power mode controller.
// Assumes a 25 MHz reference clock driving all controller logic.
package power_mode_pkg;

   localparam int REF_CLK_HZ = 25000000;
   localparam int WAKE_TIME_US = 125;
   localparam int WAKE_CYCLES = (REF_CLK_HZ / 1000000) * WAKE_TIME_US;
   localparam int LSO_TICK_HZ = 1000;
   localparam int LSO_DIV_CYCLES = REF_CLK_HZ / LSO_TICK_HZ;
   localparam int MAX_WAKE_MS = 128;
   localparam int WAKE_SEL_W = 3;
   localparam int WHEEL_W = 8;
   localparam int NUM_SUBSYS = 8;
   localparam int CPU_BIT = 0;
   localparam logic [NUM_SUBSYS-1:0] TEMPLATE_RESET = 8'hFF;
   localparam logic [WAKE_SEL_W-1:0] WAKE_SEL_RESET = 3'h7;

   typedef enum logic [2:0] {
      MODE_ACTIVE = 3'b000,
      MODE_ALT_ACTIVE = 3'b001,
      MODE_SLEEP = 3'b010,
      MODE_HIBERNATE = 3'b011,
      MODE_WAKING = 3'b100
   } power_mode_t;

   typedef enum logic [1:0] {
      REQ_NONE = 2'b00,
      REQ_ALT_ACTIVE = 2'b01,
      REQ_SLEEP = 2'b10,
      REQ_HIBERNATE = 2'b11
   } mode_req_t;

endpackage

// ---- logic/periodic_wake_timer.sv ----
// 1 kHz wheel derived from ref_clk, counting only while run is high, with a selectable period.
// Assumes rst is synchronous to ref_clk.
`timescale 1ns/10ps
module periodic_wake_timer
   import power_mode_pkg::*;
#(
   parameter int DIV_CYCLES = LSO_DIV_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic clear,
   input wire logic [WAKE_SEL_W-1:0] interval_sel,
   output logic [WHEEL_W-1:0] count,
   output logic wake_pulse
);

   logic [15:0] div_reg;
   logic tick;
   logic [WHEEL_W-1:0] wheel_reg;
   logic [WHEEL_W-1:0] period_mask;

   // Interval is 2^sel ms, longest 128 ms at sel 7
   assign period_mask = WHEEL_W'((9'h001 << interval_sel) - 9'h001);
   assign tick = run && (div_reg == 16'(DIV_CYCLES - 1));

   // Low speed oscillator stand-in: 1 kHz tick
   always_ff @(posedge ref_clk)
   begin
      if (rst || clear || !run || tick)
         div_reg <= 16'h0000;
      else
         div_reg <= div_reg + 16'h0001;
   end

   // Wheel stops in hibernate and can be cleared by firmware
   always_ff @(posedge ref_clk)
   begin
      if (rst || clear)
         wheel_reg <= '0;
      else if (tick)
         wheel_reg <= wheel_reg + WHEEL_W'(1);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || clear)
         wake_pulse <= 1'b0;
      else
         wake_pulse <= tick && ((wheel_reg & period_mask) == period_mask);
   end

   assign count = wheel_reg;

endmodule // periodic_wake_timer

// ---- logic/power_mode_controller.sv ----
// Global power mode controller: active, alternate active, sleep, hibernate.
// Assumes firmware drives the control ports from ref_clk logic; the
// external reset pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int N = NUM_SUBSYS,
   parameter int WAKE_CNT = WAKE_CYCLES,
   parameter int DIV_CYCLES = LSO_DIV_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic external_reset_pin_n,
   input wire logic [N-1:0] active_template,
   input wire logic [N-1:0] alt_template,
   input wire logic template_we,
   input wire logic mode_req_valid,
   input wire logic [1:0] mode_req,
   input wire logic leave_alt,
   input wire logic wake_timer_clear,
   input wire logic [WAKE_SEL_W-1:0] wake_interval_sel,
   input wire logic [N-1:0] gpio_out_live,
   input wire logic [N-1:0] pin_irq_cfg_live,
   output logic [2:0] power_mode,
   output logic [N-1:0] subsys_enable,
   output logic [N-1:0] subsys_clk_en,
   output logic cpu_enable,
   output logic low_speed_osc_en,
   output logic main_regulators_en,
   output logic hibernate_regulator_en,
   output logic [N-1:0] gpio_out_hold,
   output logic [N-1:0] pin_irq_cfg_hold,
   output logic [WHEEL_W-1:0] wake_timer_count,
   output logic wake_event
);

   power_mode_t mode_reg;
   power_mode_t mode_next;
   logic [N-1:0] act_tmpl_reg;
   logic [N-1:0] alt_tmpl_reg;
   logic cpu_wake_reg;
   logic external_reset_pin_meta_reg;
   logic external_reset_pin_sync_reg;
   logic external_reset_pin_seen_reg;
   logic [15:0] wake_cnt_reg;
   logic timer_wake;
   logic timer_run;
   logic [N-1:0] tmpl_sel;
   logic [N-1:0] enable_next;
   logic [N-1:0] gpio_hold_reg;
   logic [N-1:0] irq_hold_reg;
   logic in_low;

   // External reset pin: three flops before use
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         external_reset_pin_meta_reg <= 1'b1;
         external_reset_pin_sync_reg <= 1'b1;
      end
      else
      begin
         external_reset_pin_meta_reg <= external_reset_pin_n;
         external_reset_pin_sync_reg <= external_reset_pin_meta_reg;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         external_reset_pin_seen_reg <= 1'b0;
      else
         external_reset_pin_seen_reg <= !external_reset_pin_sync_reg;
   end

   assign timer_run = (mode_reg != MODE_HIBERNATE);

   periodic_wake_timer #(
      .DIV_CYCLES(DIV_CYCLES)
   ) u_wake_timer (
      .ref_clk(ref_clk),
      .rst(rst || external_reset_pin_seen_reg),
      .run(timer_run),
      .clear(wake_timer_clear),
      .interval_sel(wake_interval_sel),
      .count(wake_timer_count),
      .wake_pulse(timer_wake)
   );

   // Templates update whenever firmware writes, in any running mode
   always_ff @(posedge ref_clk)
   begin
      if (rst || external_reset_pin_seen_reg)
      begin
         act_tmpl_reg <= TEMPLATE_RESET;
         alt_tmpl_reg <= TEMPLATE_RESET;
      end
      else if (template_we && mode_reg != MODE_HIBERNATE)
      begin
         act_tmpl_reg <= active_template;
         alt_tmpl_reg <= alt_template;
      end
   end

   // Next mode: low power is entered only by a request from a running mode
   always_comb
   begin
      mode_next = mode_reg;
      unique case (mode_reg)
         MODE_ACTIVE, MODE_ALT_ACTIVE:
         begin
            if (mode_req_valid)
            begin
               unique case (mode_req_t'(mode_req))
                  REQ_ALT_ACTIVE: mode_next = MODE_ALT_ACTIVE;
                  REQ_SLEEP: mode_next = MODE_SLEEP;
                  REQ_HIBERNATE: mode_next = MODE_HIBERNATE;
                  REQ_NONE: mode_next = mode_reg;
               endcase
            end
            else if (leave_alt)
               mode_next = MODE_ACTIVE;
            else if (timer_wake)
               mode_next = MODE_ACTIVE;
         end
         MODE_SLEEP:
         begin
            if (timer_wake)
               mode_next = MODE_WAKING;
         end
         MODE_WAKING:
         begin
            if (wake_cnt_reg == 16'(WAKE_CNT - 1))
               mode_next = MODE_ACTIVE;
         end
         MODE_HIBERNATE:
            mode_next = MODE_HIBERNATE;
         default:
            mode_next = MODE_ACTIVE;
      endcase
   end

   // Mode register; a pin reset overrides every mode, hibernate included
   always_ff @(posedge ref_clk)
   begin
      if (rst || external_reset_pin_seen_reg)
         mode_reg <= MODE_ACTIVE;
      else
         mode_reg <= mode_next;
   end

   // Wake delay counter: runs only while waking, parks at its end value
   always_ff @(posedge ref_clk)
   begin
      if (rst || external_reset_pin_seen_reg || mode_reg != MODE_WAKING)
         wake_cnt_reg <= 16'h0000;
      else if (wake_cnt_reg != 16'(WAKE_CNT - 1))
         wake_cnt_reg <= wake_cnt_reg + 16'h0001;
   end

   // Processor enable forced on by any wakeup event
   always_ff @(posedge ref_clk)
   begin
      if (rst || external_reset_pin_seen_reg)
         cpu_wake_reg <= 1'b1;
      else if (timer_wake)
         cpu_wake_reg <= 1'b1;
      else if (template_we && !active_template[CPU_BIT])
         cpu_wake_reg <= 1'b0;
   end

   assign in_low = (mode_reg == MODE_SLEEP) || (mode_reg == MODE_HIBERNATE)
      || (mode_reg == MODE_WAKING);

   always_comb
   begin
      tmpl_sel = (mode_reg == MODE_ALT_ACTIVE) ? alt_tmpl_reg : act_tmpl_reg;
      enable_next = tmpl_sel;
      if (mode_reg == MODE_ACTIVE)
         enable_next[CPU_BIT] = act_tmpl_reg[CPU_BIT] || cpu_wake_reg;
      if (in_low)
         enable_next = '0;
   end

   // Output pin values track the live ones and freeze on hibernate entry
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         gpio_hold_reg <= '0;
      else if (mode_reg != MODE_HIBERNATE)
         gpio_hold_reg <= gpio_out_live;
   end

   // Pin interrupt settings freeze the same way
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         irq_hold_reg <= '0;
      else if (mode_reg != MODE_HIBERNATE)
         irq_hold_reg <= pin_irq_cfg_live;
   end

   // Subsystem enables, one cycle after the mode that selects them
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         subsys_enable <= '0;
      else
         subsys_enable <= enable_next;
   end

   // Clock gates follow the enables so a disabled block gets no clock
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         subsys_clk_en <= '0;
      else
         subsys_clk_en <= enable_next;
   end

   // Visible mode, registered to line up with the enables
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         power_mode <= 3'h0;
      else
         power_mode <= mode_reg;
   end

   // Low speed oscillator runs in every mode but hibernate
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         low_speed_osc_en <= 1'b1;
      else
         low_speed_osc_en <= (mode_reg != MODE_HIBERNATE);
   end

   // Main regulators drop out only in hibernate
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         main_regulators_en <= 1'b1;
      else
         main_regulators_en <= (mode_reg != MODE_HIBERNATE);
   end

   // One cycle pulse per timer wakeup; from the pin it stays high for as long as the pin reset is seen
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         wake_event <= 1'b0;
      else
         wake_event <= timer_wake || external_reset_pin_seen_reg;
   end

   assign cpu_enable = subsys_enable[CPU_BIT];
   assign hibernate_regulator_en = 1'b1;
   assign gpio_out_hold = gpio_hold_reg;
   assign pin_irq_cfg_hold = irq_hold_reg;

endmodule // power_mode_controller

// ---- test/power_mode_properties.sv ----
// Port checker of the power mode controller.
// Bound to the controller top; sees its ports only.
`timescale 1ns/10ps
module power_mode_checker
   import power_mode_pkg::*;
#(
   parameter int N = NUM_SUBSYS,
   parameter int WAKE_CNT = WAKE_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic external_reset_pin_n,
   input wire logic mode_req_valid,
   input wire logic [1:0] mode_req,
   input wire logic [2:0] power_mode,
   input wire logic [N-1:0] subsys_enable,
   input wire logic [N-1:0] subsys_clk_en,
   input wire logic cpu_enable,
   input wire logic low_speed_osc_en,
   input wire logic main_regulators_en,
   input wire logic hibernate_regulator_en,
   input wire logic [N-1:0] gpio_out_hold,
   input wire logic wake_event
);
   localparam int W_HI = WAKE_CNT + 2;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence hib_pin_high_s;
      (power_mode == MODE_HIBERNATE && external_reset_pin_n) [*6];
   endsequence
   sequence waking_s;
      (power_mode == MODE_WAKING) [*8];
   endsequence
   hib_regulator_a: assert property (hibernate_regulator_en)
      else $error("hibernate regulator off");
   clock_gate_a: assert property (subsys_clk_en == subsys_enable)
      else $error("clock enable differs from enable");
   sleep_off_a: assert property (power_mode == MODE_SLEEP
      |-> subsys_enable == '0 && low_speed_osc_en) else $error("sleep outputs");
   hib_off_a: assert property (power_mode == MODE_HIBERNATE
      |-> !low_speed_osc_en && !main_regulators_en) else $error("hib outputs");
   hib_hold_a: assert property (power_mode == MODE_HIBERNATE
      && $past(power_mode) == MODE_HIBERNATE |-> $stable(gpio_out_hold))
      else $error("held outputs moved");
   hib_exit_a: assert property (hib_pin_high_s
      |=> power_mode == MODE_HIBERNATE) else $error("left hibernate");
   wake_time_a: assert property ($rose(power_mode == MODE_WAKING)
      |-> waking_s ##[1:W_HI] power_mode == MODE_ACTIVE)
      else $error("wake time wrong");
   wake_cpu_a: assert property ($fell(power_mode == MODE_WAKING)
      |-> ##[0:2] cpu_enable) else $error("cpu not enabled on wake");
   sleep_req_a: assert property (power_mode == MODE_ACTIVE
      && mode_req_valid && mode_req == REQ_SLEEP && external_reset_pin_n
      |-> ##2 power_mode == MODE_SLEEP) else $error("sleep not entered");
   wake_pulse_a: assert property ($rose(power_mode == MODE_WAKING)
      |-> $past(wake_event)) else $error("no wake event pulse");
endmodule // power_mode_checker
bind power_mode_controller power_mode_checker #(.N(N), .WAKE_CNT(WAKE_CNT))
   i_chk (.ref_clk(ref_clk), .rst(rst), .power_mode(power_mode),
   .external_reset_pin_n(external_reset_pin_n), .mode_req(mode_req),
   .mode_req_valid(mode_req_valid), .subsys_enable(subsys_enable),
   .subsys_clk_en(subsys_clk_en), .cpu_enable(cpu_enable),
   .low_speed_osc_en(low_speed_osc_en), .gpio_out_hold(gpio_out_hold),
   .main_regulators_en(main_regulators_en), .wake_event(wake_event),
   .hibernate_regulator_en(hibernate_regulator_en));

// ---- test/power_mode_controller_tb.sv ----
// Self-checking bench of the power mode controller.
// Shortened wake and divider counts; inputs change at the falling edge.
`timescale 1ns/10ps
module power_mode_controller_tb;
   import power_mode_pkg::*;
   typedef struct {logic [7:0] act; logic [7:0] alt;} row_t;
   row_t rows [3] = '{'{8'hFF, 8'h0F}, '{8'hA4, 8'h3C}, '{8'h5A, 8'h00}};
   logic ref_clk = 0, rst = 1, external_reset_pin_n = 1, template_we = 0;
   logic mode_req_valid = 0, leave_alt = 0, wake_timer_clear = 1;
   logic [1:0] mode_req = 0;
   logic [2:0] wake_interval_sel = 0, power_mode;
   logic [7:0] active_template = 0, alt_template = 0, gpio_out_live = 0;
   logic [7:0] pin_irq_cfg_live = 0, subsys_enable, subsys_clk_en;
   logic [7:0] gpio_out_hold, pin_irq_cfg_hold, wake_timer_count, cnt;
   logic cpu_enable, low_speed_osc_en, main_regulators_en;
   logic hibernate_regulator_en, wake_event;
   int mismatches = 0, check_count = 0;
   power_mode_controller #(.WAKE_CNT(10), .DIV_CYCLES(4)) i_dut (.ref_clk,
      .rst, .external_reset_pin_n, .active_template, .alt_template,
      .template_we, .mode_req_valid, .mode_req, .leave_alt,
      .wake_timer_clear, .wake_interval_sel, .gpio_out_live,
      .pin_irq_cfg_live, .power_mode, .subsys_enable, .subsys_clk_en,
      .cpu_enable, .low_speed_osc_en, .main_regulators_en,
      .hibernate_regulator_en, .gpio_out_hold, .pin_irq_cfg_hold,
      .wake_timer_count, .wake_event);
   initial
   begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic chk(input string what, input logic [7:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic req(input logic [1:0] code);
      mode_req_valid = 1;
      mode_req = code;
      cyc(1);
      mode_req_valid = 0;
      cyc(3);
   endtask
   task automatic tpl(input logic [7:0] a, b);
      active_template = a;
      alt_template = b;
      template_we = 1;
      cyc(1);
      template_we = 0;
      cyc(3);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (int i = 0; i < 200 && power_mode !== m; i++) cyc(1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      complete_run();
   end
   initial
   begin
      cyc(2);
      rst = 0;
      cyc(1);
      chk("mode", 8'h00, power_mode);
      chk("enables", 8'hFF, subsys_enable);
      foreach (rows[i])
      begin
         tpl(rows[i].act, rows[i].alt);
         chk("active", rows[i].act, subsys_enable);
         req(REQ_ALT_ACTIVE);
         chk("alt mode", 8'h01, power_mode);
         chk("alt", rows[i].alt, subsys_enable);
         leave_alt = 1;
         cyc(1);
         leave_alt = 0;
         cyc(3);
         chk("back", rows[i].act, subsys_enable);
      end
      $display("template table done");
      req(REQ_SLEEP);
      chk("sleep", 8'h02, power_mode);
      req(REQ_HIBERNATE);
      chk("refused", 8'h02, power_mode);
      wake_timer_clear = 0;
      wait_mode(MODE_WAKING);
      wake_timer_clear = 1;
      chk("waking", 8'h04, power_mode);
      wait_mode(MODE_ACTIVE);
      cyc(2);
      chk("woken", 8'h00, power_mode);
      chk("cpu", 8'h01, cpu_enable);
      $display("sleep test done");
      gpio_out_live = 8'h3C;
      pin_irq_cfg_live = 8'hC3;
      req(REQ_HIBERNATE);
      chk("hib", 8'h03, power_mode);
      chk("regs", 8'h00, main_regulators_en);
      gpio_out_live = 8'h00;
      pin_irq_cfg_live = 8'hFF;
      wake_timer_clear = 0;
      cnt = wake_timer_count;
      tpl(8'h11, 8'h11);
      cyc(40);
      chk("stay", 8'h03, power_mode);
      chk("gpio", 8'h3C, gpio_out_hold);
      chk("irq cfg", 8'hC3, pin_irq_cfg_hold);
      chk("wheel", cnt, wake_timer_count);
      wake_timer_clear = 1;
      external_reset_pin_n = 0;
      cyc(4);
      external_reset_pin_n = 1;
      wait_mode(MODE_ACTIVE);
      cyc(2);
      chk("pin exit", 8'h00, power_mode);
      chk("pin enables", 8'hFF, subsys_enable);
      $display("hibernate test done");
      complete_run();
   end
endmodule // power_mode_controller_tb
